// ==== core/mirc_regs.svh ====
// Register offsets, field positions, reset values and counts of the
// MAC interrupt and receive class register slice.
// Assumes byte addresses on a 32-bit word-aligned register port.
`ifndef MIRC_REGS_SVH
`define MIRC_REGS_SVH

// Word offsets on the register port.
`define MIRC_OFF_RAW      8'h00
`define MIRC_OFF_MASKED   8'h04
`define MIRC_OFF_EN_SET   8'h08
`define MIRC_OFF_EN_CLR   8'h0c
`define MIRC_OFF_CLASS    8'h10

// Interrupt source bit positions.
`define MIRC_BIT_HOST     1
`define MIRC_BIT_STAT     0

// Receive class field positions.
`define MIRC_BIT_KEEP_FCS 30
`define MIRC_BIT_QOS      29
`define MIRC_BIT_SINGLE   28
`define MIRC_BIT_CP_CTRL  24
`define MIRC_BIT_CP_SHORT 23
`define MIRC_BIT_CP_ERR   22
`define MIRC_BIT_CP_ALL   21
`define MIRC_LSB_PROM_CH  16
`define MIRC_BIT_BC_EN    13
`define MIRC_LSB_BC_CH    8
`define MIRC_BIT_MC_EN    5
`define MIRC_LSB_MC_CH    0

// Reset values and writable bits.
`define MIRC_RST_ENABLE   2'h0
`define MIRC_RST_CLASS    32'h0000_0000
`define MIRC_CLASS_WMASK  32'h71e7_2727

// Length of the frame check sequence in bytes.
`define MIRC_FCS_BYTES    16'h0004

`endif

// ==== core/mirc_pkg.sv ====
// Types shared by the MAC interrupt and receive class register slice.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package mirc_pkg;

    // Receive filter controls decoded from the class register.
    typedef struct packed {
        logic       keep_rx_fcs;
        logic       rx_qos_enable;
        logic       rx_single_buffer;
        logic       copy_control_frames;
        logic       copy_short_frames;
        logic       copy_error_frames;
        logic       copy_all_frames;
        logic [2:0] promisc_channel;
        logic       bcast_accept_enable;
        logic [2:0] bcast_channel;
        logic       mcast_accept_enable;
        logic [2:0] mcast_channel;
    } mirc_rx_ctrl_t;

    // A received frame offered for a storage decision.
    typedef struct packed {
        logic        valid;
        logic        is_control;
        logic        is_pause;
        logic [15:0] byte_count;
        logic [15:0] buf_len;
    } mirc_frame_in_t;

    // The storage decision for one frame.
    typedef struct packed {
        logic        valid;
        logic        store;
        logic        control_flag;
        logic        pause_act;
        logic [15:0] stored_bytes;
        logic [15:0] reported_len;
    } mirc_frame_out_t;

endpackage

`default_nettype wire

// ==== core/mirc_top.sv ====
// MAC interrupt registers and receive class register with a per-frame
// storage decision stage.
// Assumes a one-cycle register port and synchronous event inputs.
`include "mirc_regs.svh"
`default_nettype none

module mirc_top (
    // Clock and reset.
    input  wire logic                      CLOCK,
    input  wire logic                      RSTN,
    // Register port.
    input  wire logic [7:0]                REG_ADDR,
    input  wire logic [31:0]               REG_WDATA,
    input  wire logic                      REG_WR,
    input  wire logic                      REG_RD,
    output var  logic [31:0]               REG_RDATA,
    // Event inputs from the MAC.
    input  wire logic                      HOST_ERROR_PENDING,
    input  wire logic                      STATS_EVENT_PENDING,
    // Interrupt request.
    output var  logic                      MAC_IRQ,
    // Receive filter controls.
    output var  mirc_pkg::mirc_rx_ctrl_t   RX_CTRL,
    // Frame decision stage.
    input  wire mirc_pkg::mirc_frame_in_t  FRAME_IN,
    output var  mirc_pkg::mirc_frame_out_t FRAME_OUT
);
    import mirc_pkg::*;

    // Length after the optional removal of the check sequence.
    function automatic logic [15:0] data_len(input logic [15:0] cnt,
                                             input logic        keep);
        logic [15:0] res;
        res = cnt;
        if (!keep) begin
            res = (cnt < `MIRC_FCS_BYTES) ? 16'h0000
                                          : 16'(cnt - `MIRC_FCS_BYTES);
        end
        return res;
    endfunction

    // Smaller of two byte counts.
    function automatic logic [15:0] min16(input logic [15:0] a,
                                          input logic [15:0] b);
        return (a < b) ? a : b;
    endfunction

    logic            rst_meta_r;
    logic            rst_sync_r;
    logic            rstn_s;
    logic [1:0]      raw_r;
    logic [1:0]      raw_nxt;
    logic [1:0]      en_r;
    logic [1:0]      en_nxt;
    logic [1:0]      masked;
    logic            irq_r;
    logic            irq_nxt;
    logic [31:0]     class_r;
    logic [31:0]     class_nxt;
    logic [31:0]     rdata_r;
    logic [31:0]     rdata_nxt;
    mirc_frame_out_t fout_r;
    mirc_frame_out_t fout_nxt;

    // Reset release through two flops; only the second is used.
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rstn_s = rst_sync_r;

    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!rstn_s);

    // Interrupt state: sources are levels held by the MAC, so raw
    // status simply samples them; there is nothing here to clear.
    assign masked = raw_r & en_r;
    always_comb begin
        raw_nxt[`MIRC_BIT_HOST] = HOST_ERROR_PENDING;
        raw_nxt[`MIRC_BIT_STAT] = STATS_EVENT_PENDING;
        en_nxt  = en_r;
        if (REG_WR && REG_ADDR == `MIRC_OFF_EN_SET) begin
            en_nxt = en_r | REG_WDATA[1:0];
        end else if (REG_WR && REG_ADDR == `MIRC_OFF_EN_CLR) begin
            en_nxt = en_r & ~REG_WDATA[1:0];
        end
        irq_nxt = |masked;
    end

    always_ff @(posedge CLOCK or negedge rstn_s) begin
        if (!rstn_s) begin
            raw_r <= 2'h0;
            en_r  <= `MIRC_RST_ENABLE;
            irq_r <= 1'b0;
        end else begin
            raw_r <= raw_nxt;
            en_r  <= en_nxt;
            irq_r <= irq_nxt;
        end
    end

    a_enable_set_bits: assert property (
        (REG_WR && REG_ADDR == `MIRC_OFF_EN_SET)
        |=> en_r == ($past(en_r) | $past(REG_WDATA[1:0])))
        else $error("Enable set write gave wrong enables.");

    a_enable_clear_bits: assert property (
        (REG_WR && REG_ADDR == `MIRC_OFF_EN_CLR)
        |=> en_r == ($past(en_r) & ~$past(REG_WDATA[1:0])))
        else $error("Enable clear write gave wrong enables.");

    a_enable_holds: assert property (
        !(REG_WR && (REG_ADDR == `MIRC_OFF_EN_SET
                  || REG_ADDR == `MIRC_OFF_EN_CLR)) |=> $stable(en_r))
        else $error("Enables changed without a write.");

    a_irq_tracks_mask: assert property (
        ##1 MAC_IRQ == $past(|masked))
        else $error("Interrupt does not follow masked status.");

    a_raw_samples_in: assert property (
        ##1 raw_r == $past({HOST_ERROR_PENDING, STATS_EVENT_PENDING}))
        else $error("Raw status does not follow event inputs.");

    // Class register: only the documented fields are writable, so
    // reserved positions can never hold anything but zero.
    always_comb begin
        class_nxt = class_r;
        if (REG_WR && REG_ADDR == `MIRC_OFF_CLASS) begin
            class_nxt = REG_WDATA & `MIRC_CLASS_WMASK;
        end
    end

    always_ff @(posedge CLOCK or negedge rstn_s) begin
        if (!rstn_s) begin
            class_r <= `MIRC_RST_CLASS;
        end else begin
            class_r <= class_nxt;
        end
    end

    a_class_write_val: assert property (
        (REG_WR && REG_ADDR == `MIRC_OFF_CLASS)
        |=> class_r == ($past(REG_WDATA) & `MIRC_CLASS_WMASK))
        else $error("Class register write stored wrong value.");

    a_class_holds_val: assert property (
        !(REG_WR && REG_ADDR == `MIRC_OFF_CLASS) |=> $stable(class_r))
        else $error("Class register changed without a write.");

    // Read mux; unmapped addresses answer zero.
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (REG_RD) begin
            case (REG_ADDR)
                `MIRC_OFF_RAW:    rdata_nxt = {30'h0, raw_r};
                `MIRC_OFF_MASKED: rdata_nxt = {30'h0, masked};
                `MIRC_OFF_EN_SET: rdata_nxt = {30'h0, en_r};
                `MIRC_OFF_EN_CLR: rdata_nxt = {30'h0, en_r};
                `MIRC_OFF_CLASS:  rdata_nxt = class_r;
                default:          rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge rstn_s) begin
        if (!rstn_s) begin
            rdata_r <= 32'h0000_0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    a_masked_read_val: assert property (
        (REG_RD && REG_ADDR == `MIRC_OFF_MASKED)
        |=> REG_RDATA == {30'h0, $past(raw_r) & $past(en_r)})
        else $error("Masked status read returned wrong value.");

    // Each word answers with the state of the cycle in which it was read.
    a_raw_read_val: assert property (
        (REG_RD && REG_ADDR == `MIRC_OFF_RAW)
        |=> REG_RDATA == {30'h0, $past(raw_r)})
        else $error("Raw status read returned wrong value.");

    a_class_read_val: assert property (
        (REG_RD && REG_ADDR == `MIRC_OFF_CLASS)
        |=> REG_RDATA == $past(class_r))
        else $error("Class register read returned wrong value.");

    a_enable_read_val: assert property (
        (REG_RD && (REG_ADDR == `MIRC_OFF_EN_SET
                 || REG_ADDR == `MIRC_OFF_EN_CLR))
        |=> REG_RDATA == {30'h0, $past(en_r)})
        else $error("Enable read returned wrong value.");

    // Frame decision: one cycle from offer to answer. The stored byte
    // count is what lands in memory; the reported length is what the
    // end descriptor carries, which in single buffer mode may exceed
    // what was stored.
    always_comb begin
        logic [15:0] len;
        len = data_len(FRAME_IN.byte_count, RX_CTRL.keep_rx_fcs);
        fout_nxt              = '0;
        fout_nxt.valid        = FRAME_IN.valid;
        if (FRAME_IN.valid) begin
            fout_nxt.reported_len = len;
            fout_nxt.stored_bytes = len;
            if (RX_CTRL.rx_single_buffer) begin
                fout_nxt.stored_bytes = min16(len, FRAME_IN.buf_len);
            end
            fout_nxt.store = !FRAME_IN.is_control
                           || RX_CTRL.copy_control_frames;
            fout_nxt.control_flag = FRAME_IN.is_control
                                  && RX_CTRL.copy_control_frames;
            // Pause handling does not depend on the copy setting.
            fout_nxt.pause_act = FRAME_IN.is_pause;
        end
    end

    always_ff @(posedge CLOCK or negedge rstn_s) begin
        if (!rstn_s) begin
            fout_r <= '0;
        end else begin
            fout_r <= fout_nxt;
        end
    end

    a_fcs_dropped_len: assert property (
        (FRAME_IN.valid && !RX_CTRL.keep_rx_fcs
         && FRAME_IN.byte_count >= `MIRC_FCS_BYTES)
        |=> FRAME_OUT.reported_len
            == 16'($past(FRAME_IN.byte_count) - `MIRC_FCS_BYTES))
        else $error("Length still counts the check sequence.");

    a_single_buf_cap: assert property (
        (FRAME_IN.valid && RX_CTRL.rx_single_buffer)
        |=> FRAME_OUT.stored_bytes <= $past(FRAME_IN.buf_len))
        else $error("Single buffer mode stored beyond buffer.");

    a_ctrl_filtered: assert property (
        (FRAME_IN.valid && FRAME_IN.is_control
         && !RX_CTRL.copy_control_frames)
        |=> FRAME_OUT.valid && !FRAME_OUT.store)
        else $error("Control frame stored while copy disabled.");

    // With the check sequence kept, the reported length must equal the
    // full byte count of the offered frame, check sequence included.
    a_fcs_kept_len: assert property (
        (FRAME_IN.valid && RX_CTRL.keep_rx_fcs)
        |=> FRAME_OUT.reported_len == $past(FRAME_IN.byte_count))
        else $error("Length leaves out a kept check sequence.");

    a_single_full_len: assert property (
        (FRAME_IN.valid && RX_CTRL.rx_single_buffer)
        |=> FRAME_OUT.stored_bytes == FRAME_OUT.reported_len
            || FRAME_OUT.stored_bytes == $past(FRAME_IN.buf_len))
        else $error("Single buffer mode cut the frame short.");

    a_ctrl_copied_flag: assert property (
        (FRAME_IN.valid && RX_CTRL.copy_control_frames)
        |=> FRAME_OUT.store
            && FRAME_OUT.control_flag == $past(FRAME_IN.is_control))
        else $error("Copied frame not stored or flagged wrongly.");

    a_pause_acted: assert property (
        FRAME_IN.valid |=> FRAME_OUT.pause_act == $past(FRAME_IN.is_pause))
        else $error("Pause frame not acted on.");

    // Outputs; filter controls are direct taps of the class flops.
    assign REG_RDATA = rdata_r;
    assign MAC_IRQ   = irq_r;
    assign FRAME_OUT = fout_r;
    assign RX_CTRL.keep_rx_fcs         = class_r[`MIRC_BIT_KEEP_FCS];
    assign RX_CTRL.rx_qos_enable       = class_r[`MIRC_BIT_QOS];
    assign RX_CTRL.rx_single_buffer    = class_r[`MIRC_BIT_SINGLE];
    assign RX_CTRL.copy_control_frames = class_r[`MIRC_BIT_CP_CTRL];
    assign RX_CTRL.copy_short_frames   = class_r[`MIRC_BIT_CP_SHORT];
    assign RX_CTRL.copy_error_frames   = class_r[`MIRC_BIT_CP_ERR];
    assign RX_CTRL.copy_all_frames     = class_r[`MIRC_BIT_CP_ALL];
    assign RX_CTRL.promisc_channel     =
        class_r[`MIRC_LSB_PROM_CH +: 3];
    assign RX_CTRL.bcast_accept_enable = class_r[`MIRC_BIT_BC_EN];
    assign RX_CTRL.bcast_channel       = class_r[`MIRC_LSB_BC_CH +: 3];
    assign RX_CTRL.mcast_accept_enable = class_r[`MIRC_BIT_MC_EN];
    assign RX_CTRL.mcast_channel       = class_r[`MIRC_LSB_MC_CH +: 3];

endmodule

`default_nettype wire

// ==== test/test_mac_irq_and_rx_class_regs.sv ====
// Self-checking bench for the MAC interrupt and receive class slice.
// Assumes the one-cycle register port and the frame stage of mirc_top.
`include "mirc_regs.svh"
`default_nettype none

module test_mac_irq_and_rx_class_regs
    import mirc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic            clock;
    logic            rstn;
    logic [7:0]      reg_addr;
    logic [31:0]     reg_wdata;
    logic            reg_wr_s;
    logic            reg_rd_s;
    logic [31:0]     reg_rdata;
    logic            host_err;
    logic            stats_ev;
    logic            mac_irq;
    mirc_rx_ctrl_t   rx_ctrl;
    mirc_frame_in_t  frame_in;
    mirc_frame_out_t frame_out;
    int              fail_count;
    int              num_checks;

    mirc_top u_dut (
        .CLOCK               (clock),
        .RSTN                (rstn),
        .REG_ADDR            (reg_addr),
        .REG_WDATA           (reg_wdata),
        .REG_WR              (reg_wr_s),
        .REG_RD              (reg_rd_s),
        .REG_RDATA           (reg_rdata),
        .HOST_ERROR_PENDING  (host_err),
        .STATS_EVENT_PENDING (stats_ev),
        .MAC_IRQ             (mac_irq),
        .RX_CTRL             (rx_ctrl),
        .FRAME_IN            (frame_in),
        .FRAME_OUT           (frame_out)
    );

    // The 125 MHz clock.
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // Any mismatch is counted and reported at once.
    task automatic check(input string name, input logic [63:0] exp,
                         input logic [63:0] got);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe; the slave never stalls.
    task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr_s  <= 1'b1;
        @(posedge clock);
        reg_wr_s  <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe is taken.
    task automatic expect_reg(input string name, input logic [7:0] a,
                              input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_rd_s <= 1'b1;
        @(posedge clock);
        reg_rd_s <= 1'b0;
        #1;
        check(name, {32'h0, exp}, {32'h0, reg_rdata});
    endtask

    // One frame offered for a storage decision, answered one cycle later.
    task automatic expect_frame(input logic ctrl, input logic pause,
                                input logic [15:0] cnt,
                                input logic [15:0] bl,
                                input mirc_frame_out_t exp);
        @(posedge clock);
        frame_in <= '{1'b1, ctrl, pause, cnt, bl};
        @(posedge clock);
        frame_in <= '0;
        #1;
        check("frame_out", {28'h0, exp}, {28'h0, frame_out});
    endtask

    // The irq output lags the masked status by a cycle, so let it settle.
    task automatic expect_irq(input logic exp);
        repeat (2) @(posedge clock);
        #1;
        check("mac_irq", {63'h0, exp}, {63'h0, mac_irq});
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // The tests take about a hundred cycles; a hang is cut off well after.
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end

    // Main sequence.
    initial begin
        fail_count = 0;
        num_checks = 0;
        rstn       = 1'b0;
        reg_addr   = 8'h00;
        reg_wdata  = 32'h0;
        reg_wr_s   = 1'b0;
        reg_rd_s   = 1'b0;
        host_err   = 1'b0;
        stats_ev   = 1'b0;
        frame_in   = '0;
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);

        // Reset values, and an unmapped address reads zero.
        expect_reg("raw", `MIRC_OFF_RAW, 32'h0);
        expect_reg("masked", `MIRC_OFF_MASKED, 32'h0);
        expect_reg("en_set", `MIRC_OFF_EN_SET, 32'h0);
        expect_reg("en_clr", `MIRC_OFF_EN_CLR, 32'h0);
        expect_reg("class", `MIRC_OFF_CLASS, 32'h0);
        expect_reg("unmapped", 8'h20, 32'h0);
        check("rx_ctrl", 64'h0, {46'h0, rx_ctrl});
        $display("test reset done");

        // Set enables; zeros leave them alone, upper bits read zero.
        write_reg(`MIRC_OFF_EN_SET, 32'h0000_0001);
        write_reg(`MIRC_OFF_EN_SET, 32'h0000_0000);
        expect_reg("en_set", `MIRC_OFF_EN_SET, 32'h1);
        write_reg(`MIRC_OFF_EN_SET, 32'hffff_fffe);
        expect_reg("en_set", `MIRC_OFF_EN_SET, 32'h3);
        expect_reg("en_clr", `MIRC_OFF_EN_CLR, 32'h3);
        $display("test enable_set done");

        // Events, masking, clearing and the request line.
        @(posedge clock);
        host_err <= 1'b1;
        repeat (3) @(posedge clock);
        expect_reg("raw", `MIRC_OFF_RAW, 32'h2);
        expect_reg("masked", `MIRC_OFF_MASKED, 32'h2);
        expect_irq(1'b1);
        @(posedge clock);
        stats_ev <= 1'b1;
        write_reg(`MIRC_OFF_EN_CLR, 32'h0000_0002);
        write_reg(`MIRC_OFF_EN_CLR, 32'h0000_0000);
        expect_reg("en_clr", `MIRC_OFF_EN_CLR, 32'h1);
        expect_reg("raw", `MIRC_OFF_RAW, 32'h3);
        expect_reg("masked", `MIRC_OFF_MASKED, 32'h1);
        expect_irq(1'b1);
        write_reg(`MIRC_OFF_EN_CLR, 32'hffff_ffff);
        expect_reg("masked", `MIRC_OFF_MASKED, 32'h0);
        expect_irq(1'b0);
        write_reg(`MIRC_OFF_RAW, 32'hffff_ffff);
        write_reg(`MIRC_OFF_MASKED, 32'hffff_ffff);
        expect_reg("raw", `MIRC_OFF_RAW, 32'h3);
        expect_reg("masked", `MIRC_OFF_MASKED, 32'h0);
        @(posedge clock);
        host_err <= 1'b0;
        stats_ev <= 1'b0;
        repeat (3) @(posedge clock);
        expect_reg("raw", `MIRC_OFF_RAW, 32'h0);
        $display("test irq done");

        // Class fields: only defined bits hold, and each lands on RX_CTRL.
        write_reg(`MIRC_OFF_CLASS, 32'hffff_ffff);
        expect_reg("class", `MIRC_OFF_CLASS, 32'h71e7_2727);
        check("rx_ctrl", 64'h3ffff, {46'h0, rx_ctrl});
        write_reg(`MIRC_OFF_CLASS, 32'h4105_2306);
        expect_reg("class", `MIRC_OFF_CLASS, 32'h4105_2306);
        check("rx_ctrl", 64'h245b6, {46'h0, rx_ctrl});
        $display("test class done");

        // Single buffer, CRC dropped, control frames filtered.
        write_reg(`MIRC_OFF_CLASS, 32'h1000_0000);
        expect_frame(1'b0, 1'b0, 16'd100, 16'd50,
                     '{1'b1, 1'b1, 1'b0, 1'b0, 16'd50, 16'd96});
        expect_frame(1'b0, 1'b0, 16'd2, 16'd50,
                     '{1'b1, 1'b1, 1'b0, 1'b0, 16'd0, 16'd0});
        expect_frame(1'b1, 1'b0, 16'd64, 16'd50,
                     '{1'b1, 1'b0, 1'b0, 1'b0, 16'd50, 16'd60});
        expect_frame(1'b1, 1'b1, 16'd64, 16'd100,
                     '{1'b1, 1'b0, 1'b0, 1'b1, 16'd60, 16'd60});
        // CRC kept, chaining allowed, control frames copied and flagged.
        write_reg(`MIRC_OFF_CLASS, 32'h4100_0000);
        expect_frame(1'b1, 1'b0, 16'd100, 16'd50,
                     '{1'b1, 1'b1, 1'b1, 1'b0, 16'd100, 16'd100});
        expect_frame(1'b1, 1'b1, 16'hffff, 16'd10,
                     '{1'b1, 1'b1, 1'b1, 1'b1, 16'hffff, 16'hffff});
        $display("test frames done");

        give_verdict();
    end

endmodule

`default_nettype wire
